// ==== logic/snc_pkg.sv ====
// package: timing constants, cycle codes and states for the scan/network sync block
package snc_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned BASE_TICK_US = 500;
  localparam int unsigned BASE_TICK_CYC = BASE_TICK_US * CLK_MHZ;
  localparam int unsigned BASE_CNT_W = 16;
  localparam int unsigned SCAN_W = 6;
  localparam int unsigned CYC_W = 2;
  localparam int unsigned NET_CH = 2;
  localparam logic [CYC_W-1:0] CYC_0P5MS = 2'h0;
  localparam logic [CYC_W-1:0] CYC_1MS = 2'h1;
  localparam logic [CYC_W-1:0] CYC_1P5MS = 2'h2;
  localparam logic [CYC_W-1:0] CYC_2MS = 2'h3;
  localparam logic [SCAN_W-1:0] SCAN_RST = 6'h02;
  localparam logic [CYC_W-1:0] NCYC_RST = 2'h0;
  localparam logic [3:0] HANDOFF_POS = 4'h1;
  typedef enum logic [1:0] {SNC_ST_INIT, SNC_ST_ALIGN, SNC_ST_SYNC, SNC_ST_FREE} snc_state_t;
endpackage

// ==== logic/snc_tick_if.sv ====
// interface: shared base tick from divider to sync logic
`timescale 1ns/100ps
interface snc_tick_if;
  logic base_tick;
  logic [snc_pkg::BASE_CNT_W-1:0] phase;
  modport src (output base_tick, output phase);
  modport dst (input base_tick, input phase);
endinterface // snc_tick_if

// ==== logic/snc_base_div.sv ====
// base tick divider: one-cycle enable every base period
`timescale 1ns/100ps
module snc_base_div
  import snc_pkg::*;
#(
  // base period in clocks; only a bench shortens it
  parameter int unsigned TICK_CYC = BASE_TICK_CYC
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  snc_tick_if.src tk
);
  typedef struct packed {
    logic [BASE_CNT_W-1:0] cnt;
    logic tick;
  } snc_div_t;
  snc_div_t s_q, s_d;
  localparam logic [BASE_CNT_W-1:0] LAST = BASE_CNT_W'(TICK_CYC - 1);

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == LAST) begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tk.base_tick = s_q.tick;
  assign tk.phase = s_q.cnt;
endmodule // snc_base_div

// ==== logic/snc_cycle_sync.sv ====
// top: aligns scan period start with network transmission cycle start
// Notes on behaviour
// - sync only when scan period at alignment is an integer multiple of network cycle; later scan period changes are not checked
// - in sync, each scan starts on a network cycle start, all channels, while the scan period stays a multiple of both cycles
// - in sync, commands hand off at one fixed point in the cycle
// - synchronisation is set up automatically after power-on reset
// - scan period change keeps optional network cycles running unbroken
// - builtin channel cycle change may lose sync until re-initialised
// - in sync, optional channel cycle change to legal combo resyncs automatically at the next scan start
`timescale 1ns/100ps
module snc_cycle_sync
  import snc_pkg::*;
#(
  parameter int unsigned TICK_CYC = BASE_TICK_CYC
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [SCAN_W-1:0] i_scan_ticks,
  input wire logic [CYC_W-1:0] i_builtin_network_channel_cyc,
  input wire logic [CYC_W-1:0] i_opt_net_cyc,
  input wire logic i_cmd_valid,
  output logic o_scan_start,
  output logic o_builtin_network_channel_start,
  output logic o_opt_net_start,
  output logic o_cmd_handoff,
  output logic o_synced,
  output logic o_builtin_lost
);
  typedef struct packed {
    snc_state_t st;
    logic [SCAN_W-1:0] scan_per;
    logic [SCAN_W-1:0] scan_cnt;
    logic [CYC_W-1:0] bcyc;
    logic [CYC_W-1:0] bcyc_live;
    logic [CYC_W-1:0] ocyc;
    logic [CYC_W-1:0] bcnt;
    logic [CYC_W-1:0] ocnt;
    logic pend;
    logic scan_p;
    logic b_p;
    logic o_p;
    logic hand_p;
    logic lost;
    logic [SCAN_W-1:0] s1, s2;
    logic [CYC_W-1:0] b1, b2, o1, o2;
    logic c1, c2;
  } snc_state_s_t;
  snc_state_s_t s_q, s_d;
  snc_tick_if tk();

  snc_base_div #(
    .TICK_CYC(TICK_CYC)
  ) u_div (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .tk(tk.src)
  );

  function automatic logic [SCAN_W-1:0] cyc_ticks(input logic [CYC_W-1:0] c);
    cyc_ticks = SCAN_W'(c) + 6'h01;
  endfunction

  function automatic logic can_sync(input logic [SCAN_W-1:0] sp, input logic [CYC_W-1:0] c);
    logic [SCAN_W-1:0] n;
    n = cyc_ticks(c);
    can_sync = (sp != '0) && ((sp % n) == '0);
  endfunction

  logic b_edge, o_edge;
  logic [SCAN_W-1:0] scan_eff;
  always_comb begin
    b_edge = (s_q.bcnt == s_q.bcyc);
    o_edge = (s_q.ocnt == s_q.ocyc);
    scan_eff = (s_q.scan_per == '0) ? 6'h01 : s_q.scan_per;
  end

  always_comb begin
    s_d = s_q;
    s_d.s1 = i_scan_ticks;
    s_d.s2 = s_q.s1;
    s_d.b1 = i_builtin_network_channel_cyc;
    s_d.b2 = s_q.b1;
    s_d.o1 = i_opt_net_cyc;
    s_d.o2 = s_q.o1;
    s_d.c1 = i_cmd_valid;
    s_d.c2 = s_q.c1;
    s_d.scan_p = 1'b0;
    s_d.b_p = 1'b0;
    s_d.o_p = 1'b0;
    s_d.hand_p = 1'b0;
    if (s_q.c2) begin
      s_d.pend = 1'b1;
    end
    if (tk.phase == BASE_CNT_W'(HANDOFF_POS) && s_q.scan_cnt == '0 && s_q.pend) begin
      s_d.hand_p = 1'b1;
      s_d.pend = s_q.c2;
    end
    if (s_q.b2 != s_q.bcyc_live && s_q.st != SNC_ST_INIT) begin
      s_d.lost = 1'b1;
      s_d.bcyc_live = s_q.b2;
    end
    case (s_q.st)
      SNC_ST_INIT: begin
        s_d.scan_per = s_q.s2;
        s_d.bcyc = s_q.b2;
        s_d.bcyc_live = s_q.b2;
        s_d.ocyc = s_q.o2;
        s_d.lost = 1'b0;
        if (tk.base_tick) begin
          s_d.st = SNC_ST_ALIGN;
        end
      end
      SNC_ST_ALIGN: begin
        if (tk.base_tick) begin
          s_d.scan_cnt = '0;
          s_d.bcnt = '0;
          s_d.ocnt = '0;
          s_d.scan_p = 1'b1;
          s_d.b_p = 1'b1;
          s_d.o_p = 1'b1;
          s_d.st = (can_sync(s_q.scan_per, s_q.bcyc) && can_sync(s_q.scan_per, s_q.ocyc))
            ? SNC_ST_SYNC : SNC_ST_FREE;
        end
      end
      default: begin
        if (tk.base_tick) begin
          s_d.bcnt = b_edge ? '0 : s_q.bcnt + 1'b1;
          s_d.ocnt = o_edge ? '0 : s_q.ocnt + 1'b1;
          s_d.b_p = b_edge;
          s_d.o_p = o_edge;
          s_d.scan_cnt = (s_q.scan_cnt >= scan_eff - 1'b1) ? '0 : s_q.scan_cnt + 1'b1;
          s_d.scan_p = (s_q.scan_cnt >= scan_eff - 1'b1);
          if (s_q.st == SNC_ST_FREE) begin
            // free mode: scan restarts on its own count, not on a cycle start
            s_d.scan_per = s_q.s2;
          end else if (s_q.scan_cnt >= scan_eff - 1'b1) begin
            // scan boundary is a cycle boundary while the scan period is a multiple of both cycles
            s_d.scan_per = s_q.s2;
            if (s_q.o2 != s_q.ocyc && can_sync(s_q.s2, s_q.o2)) begin
              s_d.ocyc = s_q.o2;
              s_d.ocnt = '0;
              s_d.o_p = 1'b1;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '0;
      s_q.st <= SNC_ST_INIT;
      s_q.scan_per <= SCAN_RST;
      s_q.bcyc <= NCYC_RST;
      s_q.bcyc_live <= NCYC_RST;
      s_q.ocyc <= NCYC_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_scan_start = s_q.scan_p;
  assign o_builtin_network_channel_start = s_q.b_p;
  assign o_opt_net_start = s_q.o_p;
  assign o_cmd_handoff = s_q.hand_p;
  assign o_synced = (s_q.st == SNC_ST_SYNC) && !s_q.lost;
  assign o_builtin_lost = s_q.lost;
endmodule // snc_cycle_sync

// ==== testbench/snc_host_model.sv ====
// model: scan scheduler on the far side, always holding commands
`timescale 1ns/100ps
module snc_host_model (
  input wire logic i_clk,
  input wire logic i_rst,
  output logic o_cmd_valid
);
  logic cmd_q;
  // period fixed
  // the scan period is changed only by a full reset of the bench
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cmd_q <= 1'b0;
    end else begin
      cmd_q <= 1'b1;
    end
  end
  assign o_cmd_valid = cmd_q;
endmodule // snc_host_model

// ==== testbench/snc_cycle_sync_props.sv ====
// checker: timing relations at the sync block ports
`timescale 1ns/100ps
module snc_props (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic o_scan_start,
  input wire logic o_builtin_network_channel_start,
  input wire logic o_opt_net_start,
  input wire logic o_cmd_handoff,
  input wire logic o_synced,
  input wire logic o_builtin_lost
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  chk_net_align:
    assert property (o_synced && o_scan_start |-> o_builtin_network_channel_start
      && o_opt_net_start) else $error("scan start off cycle start");
  chk_handoff_pos:
    assert property (o_synced && o_cmd_handoff |-> $past(o_scan_start))
      else $error("handoff off position");
  chk_quiet_boot:
    assert property ($fell(i_rst) |-> !o_scan_start [*8]) else $error("early scan");
  chk_opt_gap:
    assert property (o_opt_net_start |=> !o_opt_net_start [*8]) else $error("opt gap");
  chk_scan_gap:
    assert property (o_scan_start |=> !o_scan_start [*8]) else $error("scan gap");
  chk_mode_hold:
    assert property (o_synced && !o_builtin_lost |=> o_synced || o_builtin_lost)
      else $error("mode flipped");
  chk_lost_hold:
    assert property (o_builtin_lost |=> o_builtin_lost && !o_synced)
      else $error("lost flag");
  chk_handoff_one:
    assert property (o_cmd_handoff |=> !o_cmd_handoff) else $error("long handoff");
endmodule // snc_props
bind snc_cycle_sync snc_props u_props (.i_clk(i_clk), .i_rst(i_rst),
  .o_scan_start(o_scan_start), .o_opt_net_start(o_opt_net_start),
  .o_builtin_network_channel_start(o_builtin_network_channel_start),
  .o_cmd_handoff(o_cmd_handoff), .o_synced(o_synced), .o_builtin_lost(o_builtin_lost));

// ==== testbench/scan_network_cycle_sync_bench.sv ====
// bench: power-on sync, builtin cycle change, unsynced combination
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
  $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module scan_network_cycle_sync_bench;
  import snc_pkg::*;
  // short base period keeps the run small; ratios are unchanged
  localparam int unsigned TB_TICK = 100;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [SCAN_W-1:0] scan = 6'h02;
  logic [CYC_W-1:0] bcyc = CYC_0P5MS;
  logic [CYC_W-1:0] ocyc = CYC_1MS;
  logic cmd, scan_st, b_st, o_st, hand, synced, lost;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #5 i_clk = ~i_clk;
  snc_cycle_sync #(.TICK_CYC(TB_TICK)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_scan_ticks(scan),
    .i_builtin_network_channel_cyc(bcyc), .i_opt_net_cyc(ocyc), .i_cmd_valid(cmd),
    .o_scan_start(scan_st), .o_builtin_network_channel_start(b_st),
    .o_opt_net_start(o_st), .o_cmd_handoff(hand), .o_synced(synced), .o_builtin_lost(lost));
  snc_host_model u_host (.i_clk(i_clk), .i_rst(i_rst), .o_cmd_valid(cmd));
  task automatic results;
    if (bad_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // two power-ups of a few base periods each bound the run
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      results();
    end
  end
  task automatic por(input logic [SCAN_W-1:0] s, input logic [CYC_W-1:0] b);
    @(posedge i_clk);
    i_rst <= 1'b1;
    scan <= s;
    bcyc <= b;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
  endtask
  task automatic wait_scan(output int n);
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (scan_st !== 1'b1 && n < 2000);
  endtask
  task automatic t_synced;
    int n;
    por(6'h02, CYC_0P5MS);
    wait_scan(n);
    `CHK(synced, 1'b1)
    `CHK({b_st, o_st}, 2'h3)
    `CHK(n, 2 * TB_TICK + 2)
    @(negedge i_clk);
    `CHK(hand, 1'b1)
    wait_scan(n);
    `CHK(n, 2 * TB_TICK - 1)
    @(posedge i_clk);
    bcyc <= CYC_1MS;
    repeat (5) @(negedge i_clk);
    `CHK({lost, synced}, 2'h2)
  endtask
  task automatic t_free;
    int n;
    por(6'h03, CYC_1MS);
    wait_scan(n);
    `CHK(synced, 1'b0)
  endtask
  initial begin
    t_synced();
    t_free();
    results();
  end
endmodule // scan_network_cycle_sync_bench
